// >>> hdl/ddai_pkg.sv
// Constants shared by the incremental integrator module
package ddai_pkg;
	// ============================================================
	// Clock and iteration timing
	localparam longint CLK_HZ        = 20_000_000;
	localparam longint ITER_TIME_NS  = 10_000;
	localparam longint NS_PER_S      = 1_000_000_000;
	localparam int     ITER_CYCLES   = int'((ITER_TIME_NS * CLK_HZ) / NS_PER_S);
	localparam int     DIV_W         = 8;
	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(ITER_CYCLES - 1);
	localparam logic [DIV_W-1:0] DIV_RESET = 8'h00;

	// ============================================================
	// Register word layout: sign, computing bits, scaling marker, zeros
	localparam int WORD_W        = 28;
	localparam int SIGN_POS      = 27;
	localparam int MAX_COMPUTE   = 26;
	localparam logic [WORD_W-1:0] WORD_RESET = 28'h0000000;
	localparam logic [WORD_W-1:0] MARKER_RESET = 28'h0000001;

	// ============================================================
	// Analog converter accumulator span
	localparam int DAC_W = 15;
	localparam logic signed [DAC_W-1:0] DAC_MAX = 15'sh2000;
	localparam logic signed [DAC_W-1:0] DAC_MIN = -15'sh2000;
	localparam logic signed [DAC_W-1:0] DAC_RESET = 15'sh0000;
endpackage

// >>> hdl/ddai_integrator.sv
// Incremental integrator module of a digital differential analyzer
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - One iteration per fixed machine-time increment
// - Integrand range is minus one to below one
// - Negative output carries increments with reversed sign
// - Flag overflow when operand exceeds register capacity
// - Word is sign, computing bits, marker, zeros
// - Negative contents held in two's complement
// - Converter accumulator spans plus/minus two^13 increments
// - Increments travel as existence plus sign lines
// - Any overflow drives one common overflow signal
// - Lowest one bit is the scaling marker
module ddai_integrator (
	input  wire logic                              mclk,
	input  wire logic                              arst_n,
	input  wire logic                              fill_load,
	input  wire logic [ddai_pkg::WORD_W-1:0]       fill_word,
	input  wire logic                              ovf_clear,
	input  wire logic                              sec_exist,
	input  wire logic                              sec_pos,
	input  wire logic                              pri_exist,
	input  wire logic                              pri_pos,
	input  wire logic                              ovf_chain_in,
	output logic                                   iter_tick,
	output logic                                   z_exist,
	output logic                                   z_pos,
	output logic                                   zn_exist,
	output logic                                   zn_pos,
	output logic                                   ovf,
	output logic                                   ovf_common,
	output logic [ddai_pkg::WORD_W-1:0]            y_word,
	output logic signed [ddai_pkg::DAC_W-1:0]      dac_level
);

	// ============================================================
	// Reset release
	logic rst_meta_n;
	logic rst_n;

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			rst_meta_n <= 1'b0;
			rst_n      <= 1'b0;
		end else begin
			rst_meta_n <= 1'b1;
			rst_n      <= rst_meta_n;
		end
	end

	// ============================================================
	// Helpers
	function automatic logic [ddai_pkg::WORD_W-1:0] lowest_one(
		input logic [ddai_pkg::WORD_W-1:0] w);
		return w & (~w + ddai_pkg::WORD_W'(1));
	endfunction

	function automatic logic [ddai_pkg::WORD_W:0] sext_add(
		input logic [ddai_pkg::WORD_W-1:0] a,
		input logic [ddai_pkg::WORD_W-1:0] b);
		return {a[ddai_pkg::SIGN_POS], a} + {b[ddai_pkg::SIGN_POS], b};
	endfunction

	// ============================================================
	// Machine-time divider
	logic [ddai_pkg::DIV_W-1:0] div_cnt;
	logic [ddai_pkg::DIV_W-1:0] next_div_cnt;
	logic                       next_iter_tick;

	always_comb begin
		next_iter_tick = (div_cnt == ddai_pkg::DIV_LAST);
		next_div_cnt   = next_iter_tick ? ddai_pkg::DIV_RESET : div_cnt + 8'h01;
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			div_cnt   <= ddai_pkg::DIV_RESET;
			iter_tick <= 1'b0;
		end else begin
			div_cnt   <= next_div_cnt;
			iter_tick <= next_iter_tick;
		end
	end

	// ============================================================
	// Integrand, remainder and outputs
	logic [ddai_pkg::WORD_W-1:0] marker;
	logic [ddai_pkg::WORD_W-1:0] rem;
	logic [ddai_pkg::WORD_W-1:0] y_val;
	logic [ddai_pkg::WORD_W-1:0] unit;
	logic [ddai_pkg::WORD_W:0]   y_sum;
	logic [ddai_pkg::WORD_W:0]   r_sum;
	logic                        y_ovf;
	logic                        next_ovf;
	logic [ddai_pkg::WORD_W-1:0] next_y_word;
	logic [ddai_pkg::WORD_W-1:0] next_marker;
	logic [ddai_pkg::WORD_W-1:0] next_rem;
	logic                        next_z_exist;
	logic                        next_z_pos;
	logic signed [ddai_pkg::DAC_W-1:0] next_dac;

	always_comb begin
		y_val = y_word & ~marker;
		unit  = marker << 1;
		y_sum = sext_add(y_val, sec_pos ? unit : (~unit + 28'h0000001));
		// Range is [-1,1); a sum that leaves it is refused, not wrapped
		y_ovf = sec_exist && (y_sum[ddai_pkg::WORD_W] != y_sum[ddai_pkg::SIGN_POS]);
		// The primary path uses the integrand from before this iteration
		r_sum = sext_add(rem, pri_pos ? y_val : (~y_val + 28'h0000001));
		next_y_word  = y_word;
		next_marker  = marker;
		next_rem     = rem;
		next_z_exist = z_exist;
		next_z_pos   = z_pos;
		next_dac     = dac_level;
		next_ovf     = ovf && !ovf_clear;
		if (fill_load) begin
			next_y_word = fill_word;
			next_marker = lowest_one(fill_word);
			next_rem    = ddai_pkg::WORD_RESET;
		end else if (iter_tick) begin
			if (sec_exist && !y_ovf) begin
				next_y_word = y_sum[ddai_pkg::WORD_W-1:0] | marker;
			end
			if (y_ovf) begin
				next_ovf = 1'b1;
			end
			next_z_exist = 1'b0;
			if (pri_exist) begin
				next_rem = r_sum[ddai_pkg::WORD_W-1:0];
				if (r_sum[ddai_pkg::WORD_W] != r_sum[ddai_pkg::SIGN_POS]) begin
					next_z_exist = 1'b1;
					next_z_pos   = !r_sum[ddai_pkg::WORD_W];
				end
			end
			if (next_z_exist) begin
				if (next_z_pos && dac_level != ddai_pkg::DAC_MAX) begin
					next_dac = dac_level + 15'sh0001;
				end else if (!next_z_pos && dac_level != ddai_pkg::DAC_MIN) begin
					next_dac = dac_level - 15'sh0001;
				end
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			y_word     <= ddai_pkg::WORD_RESET;
			marker     <= ddai_pkg::MARKER_RESET;
			rem        <= ddai_pkg::WORD_RESET;
			z_exist    <= 1'b0;
			z_pos      <= 1'b0;
			zn_exist   <= 1'b0;
			zn_pos     <= 1'b1;
			ovf        <= 1'b0;
			ovf_common <= 1'b0;
			dac_level  <= ddai_pkg::DAC_RESET;
		end else begin
			y_word     <= next_y_word;
			marker     <= next_marker;
			rem        <= next_rem;
			z_exist    <= next_z_exist;
			z_pos      <= next_z_pos;
			zn_exist   <= next_z_exist;
			zn_pos     <= !next_z_pos;
			ovf        <= next_ovf;
			// Set wins over clear, so a late overflow is never lost
			ovf_common <= next_ovf || ovf_chain_in;
			dac_level  <= next_dac;
		end
	end

	// ============================================================
	// Assertions
	sequence sec_up_s;
		iter_tick && !fill_load && sec_exist && sec_pos && !y_ovf;
	endsequence

	sequence sec_down_s;
		iter_tick && !fill_load && sec_exist && !sec_pos && !y_ovf;
	endsequence

	tick_spacing_a: assert property (@(posedge mclk) disable iff (!rst_n)
		iter_tick |=> !iter_tick [*8])
		else $error("iteration ticks too close");
	tick_phase_a: assert property (@(posedge mclk) disable iff (!rst_n)
		iter_tick |-> div_cnt == ddai_pkg::DIV_RESET && $past(div_cnt) == ddai_pkg::DIV_LAST)
		else $error("iteration tick off its period");
	neg_output_a: assert property (@(posedge mclk) disable iff (!rst_n)
		zn_exist == z_exist && zn_pos == !z_pos)
		else $error("negative output does not mirror");
	sec_up_a: assert property (@(posedge mclk) disable iff (!rst_n)
		sec_up_s |=> y_val == $past(y_val) + $past(unit))
		else $error("secondary increment not added");
	sec_down_a: assert property (@(posedge mclk) disable iff (!rst_n)
		sec_down_s |=> y_val == $past(y_val) - $past(unit))
		else $error("secondary decrement not applied");
	range_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
		iter_tick && !fill_load && y_ovf |=> $stable(y_word) && ovf)
		else $error("out of range value accepted");
	ovf_common_a: assert property (@(posedge mclk) disable iff (!rst_n)
		((ovf && !ovf_clear) || ovf_chain_in) |=> ovf_common)
		else $error("common overflow missing");
	fill_load_a: assert property (@(posedge mclk) disable iff (!rst_n)
		fill_load |=> y_word == $past(fill_word) && rem == ddai_pkg::WORD_RESET)
		else $error("fill word not loaded");
	marker_keep_a: assert property (@(posedge mclk) disable iff (!rst_n)
		!fill_load |=> marker == $past(marker))
		else $error("scaling marker moved");
	out_stand_a: assert property (@(posedge mclk) disable iff (!rst_n)
		!iter_tick && !fill_load |=> $stable(z_exist) && $stable(z_pos))
		else $error("output changed inside an iteration");
	no_primary_a: assert property (@(posedge mclk) disable iff (!rst_n)
		iter_tick && !fill_load && !pri_exist |=> !z_exist && $stable(rem))
		else $error("output without primary increment");
	dac_span_a: assert property (@(posedge mclk) disable iff (!rst_n)
		dac_level <= ddai_pkg::DAC_MAX && dac_level >= ddai_pkg::DAC_MIN)
		else $error("converter level out of span");

endmodule
`default_nettype wire

// >>> verif/ddai_peer.sv
// Peer module model that drives the increment lines of the integrator
`timescale 1ns/10ps
`default_nettype none
module ddai_peer (
	input  wire logic mclk,
	input  wire logic arst_n,
	input  wire logic iter_tick,
	input  wire logic want_sec,
	input  wire logic want_sec_pos,
	input  wire logic want_pri,
	input  wire logic want_pri_pos,
	output logic      sec_exist,
	output logic      sec_pos,
	output logic      pri_exist,
	output logic      pri_pos
);
	// ============================================================
	// Increment lines
	// Lines change only just after a tick, so each increment stands one whole iteration
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			sec_exist <= 1'b0;
			sec_pos <= 1'b0;
			pri_exist <= 1'b0;
			pri_pos <= 1'b0;
		end else if (iter_tick) begin
			sec_exist <= want_sec;
			// Without existence the sign means nothing, so it is scrambled on purpose
			sec_pos <= want_sec ? want_sec_pos : ~sec_pos;
			pri_exist <= want_pri;
			pri_pos <= want_pri ? want_pri_pos : ~pri_pos;
		end
	end
endmodule
`default_nettype wire

// >>> verif/tb_ddai_integrator.sv
// Self-checking bench for the incremental integrator module
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin fail_count++; \
	$display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module tb_ddai_integrator;
	logic                              mclk = 1'b0;
	logic                              arst_n = 1'b0;
	logic                              fill_load = 1'b0;
	logic                              ovf_clear = 1'b0;
	logic                              ovf_chain_in = 1'b0;
	logic                              want_sec = 1'b0;
	logic                              want_sec_pos = 1'b0;
	logic                              want_pri = 1'b0;
	logic                              want_pri_pos = 1'b0;
	logic [ddai_pkg::WORD_W-1:0]       fill_word = 28'h0000000;
	logic                              sec_exist, sec_pos, pri_exist, pri_pos, iter_tick;
	logic                              z_exist, z_pos, zn_exist, zn_pos, ovf, ovf_common;
	logic [ddai_pkg::WORD_W-1:0]       y_word;
	logic signed [ddai_pkg::DAC_W-1:0] dac_level;
	int                                fail_count = 0;
	int                                checked = 0;

	ddai_integrator i_dut (.mclk, .arst_n, .fill_load, .fill_word, .ovf_clear, .sec_exist,
		.sec_pos, .pri_exist, .pri_pos, .ovf_chain_in, .iter_tick, .z_exist, .z_pos,
		.zn_exist, .zn_pos, .ovf, .ovf_common, .y_word, .dac_level);
	ddai_peer i_peer (.mclk, .arst_n, .iter_tick, .want_sec, .want_sec_pos, .want_pri,
		.want_pri_pos, .sec_exist, .sec_pos, .pri_exist, .pri_pos);

	// ============================================================
	// Shared tasks
	task automatic tick(output int n);
		n = 0;
		do begin
			@(negedge mclk);
			n++;
		end while (iter_tick !== 1'b1 && n < 300);
		@(posedge mclk);
	endtask
	// Peer loads at one tick, the module takes the increment at the next
	task automatic step(input logic s, input logic sp, input logic p, input logic pp);
		int n;
		@(posedge mclk);
		want_sec <= s;
		want_sec_pos <= sp;
		want_pri <= p;
		want_pri_pos <= pp;
		tick(n);
		want_sec <= 1'b0;
		want_pri <= 1'b0;
		tick(n);
		`CHK("tick spacing", 200, n)
		@(negedge mclk);
	endtask
	task automatic fill(input logic [ddai_pkg::WORD_W-1:0] w);
		@(posedge mclk);
		fill_load <= 1'b1;
		fill_word <= w;
		@(posedge mclk);
		fill_load <= 1'b0;
		@(negedge mclk);
		`CHK("fill y_word", w, y_word)
	endtask
	task automatic clear_ovf();
		@(posedge mclk);
		ovf_clear <= 1'b1;
		@(posedge mclk);
		ovf_clear <= 1'b0;
		repeat (2) @(negedge mclk);
		`CHK("ovf cleared", 1'b0, ovf_common)
	endtask

	// ============================================================
	// Scenarios
	task automatic test_steps();
		fill(28'h0002000);
		step(1'b1, 1'b1, 1'b0, 1'b0);
		`CHK("y plus one", 28'h0006000, y_word)
		step(1'b1, 1'b0, 1'b0, 1'b0);
		step(1'b1, 1'b0, 1'b0, 1'b0);
		`CHK("y minus one", 28'hFFFE000, y_word)
		$display("test_steps done");
	endtask
	task automatic test_ovf();
		fill(28'h7FFE000);
		step(1'b1, 1'b1, 1'b0, 1'b0);
		`CHK("y at top", 28'h7FFE000, y_word)
		`CHK("ovf top", 1'b1, ovf)
		`CHK("ovf_common", 1'b1, ovf_common)
		clear_ovf();
		fill(28'h8002000);
		step(1'b1, 1'b0, 1'b0, 1'b0);
		`CHK("y at bottom", 28'h8002000, y_word)
		`CHK("ovf bottom", 1'b1, ovf)
		clear_ovf();
		@(posedge mclk);
		ovf_chain_in <= 1'b1;
		@(posedge mclk);
		@(negedge mclk);
		`CHK("chain in", 1'b1, ovf_common)
		`CHK("own ovf quiet", 1'b0, ovf)
		@(posedge mclk);
		ovf_chain_in <= 1'b0;
		repeat (2) @(negedge mclk);
		`CHK("chain gone", 1'b0, ovf_common)
		$display("test_ovf done");
	endtask
	task automatic test_out();
		fill(28'h4002000);
		step(1'b0, 1'b0, 1'b1, 1'b1);
		`CHK("no carry", 1'b0, z_exist)
		step(1'b0, 1'b0, 1'b1, 1'b1);
		`CHK("z_exist", 1'b1, z_exist)
		`CHK("z_pos", 1'b1, z_pos)
		`CHK("zn_exist", 1'b1, zn_exist)
		`CHK("zn_pos", 1'b0, zn_pos)
		`CHK("dac up", 15'sh0001, dac_level)
		fill(28'hC002000);
		step(1'b0, 1'b0, 1'b1, 1'b1);
		step(1'b0, 1'b0, 1'b1, 1'b1);
		`CHK("no carry neg", 1'b0, z_exist)
		step(1'b0, 1'b0, 1'b1, 1'b1);
		`CHK("z_pos neg", 1'b0, z_pos)
		`CHK("zn_pos neg", 1'b1, zn_pos)
		`CHK("dac back", 15'sh0000, dac_level)
		$display("test_out done");
	endtask
	// Negative primary sign, with a secondary step in the same iteration
	task automatic test_neg();
		fill(28'h3FFE000);
		step(1'b1, 1'b0, 1'b1, 1'b0);
		`CHK("y after down", 28'h3FFA000, y_word)
		`CHK("no carry down", 1'b0, z_exist)
		step(1'b0, 1'b0, 1'b1, 1'b0);
		`CHK("no carry down 2", 1'b0, z_exist)
		step(1'b0, 1'b0, 1'b1, 1'b0);
		`CHK("z_exist down", 1'b1, z_exist)
		`CHK("z_pos down", 1'b0, z_pos)
		`CHK("zn_pos down", 1'b1, zn_pos)
		`CHK("dac below zero", 15'h7FFF, dac_level)
		$display("test_neg done");
	endtask

	// ============================================================
	// Run control
	task automatic conclude();
		$display("checked %0d fail_count %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		forever #25 mclk = ~mclk;
	end
	initial begin
		repeat (10) @(posedge mclk);
		arst_n <= 1'b1;
		repeat (4) @(negedge mclk);
		`CHK("reset y_word", 28'h0000000, y_word)
		`CHK("reset zn_pos", 1'b1, zn_pos)
		$display("test_reset done");
		test_steps();
		test_ovf();
		test_out();
		test_neg();
		conclude();
	end
	// Tests need about 5000 cycles; the limit leaves ample margin
	initial begin
		repeat (40000) @(posedge mclk);
		fail_count++;
		conclude();
	end
endmodule
`default_nettype wire
